// [src/mgl_pkg.sv]
/*
 package for the manual genlock ratio setup block: host map, field layout,
 reset values, timing counts, carrier structs and the audio constant decode.
 assumes a 16-bit host word port on sys_clk, one word per host address.
*/
// Contract
// - writing 19h makes the device start the frame-based counter reset.
// - program 17h or 18h/19h; if all three, two separate counter resets occur.
// - audio follows video clock by default; custom clocks need manual audio dividers.
// - n is 3072, or 1024/1536 when rate select is 100b, per 384fs bit.
// - 384fs enable sits at bit 5 of 31h and resets to zero.
// - locking runs from reference applied until lock-lost goes low.
// - default crash lock, duration set by crash time field of 24h.
// - bit 1 of 16h high selects drift lock.
// - reference lost then reapplied while genlocking gives drift lock.
// - genlock attempted only while reference-lost and genlock request are low.
package mgl_pkg;

    // host word addresses
    localparam logic [7:0] ADDR_LOCK_CTL = 8'h16;
    localparam logic [7:0] ADDR_LINE_DEN = 8'h17;
    localparam logic [7:0] ADDR_FRAME_DEN = 8'h18;
    localparam logic [7:0] ADDR_FRAME_INIT = 8'h19;
    localparam logic [7:0] ADDR_CRASH_CTL = 8'h24;
    localparam logic [7:0] ADDR_VNUM_LO = 8'h28;
    localparam logic [7:0] ADDR_VNUM_HI = 8'h29;
    localparam logic [7:0] ADDR_VDEN_LO = 8'h2A;
    localparam logic [7:0] ADDR_VDEN_HI = 8'h2B;
    localparam logic [7:0] ADDR_ACFG = 8'h31;
    localparam logic [7:0] ADDR_ANUM_LO = 8'h3B;
    localparam logic [7:0] ADDR_ANUM_HI = 8'h3C;
    localparam logic [7:0] ADDR_ADEN_LO = 8'h3D;
    localparam logic [7:0] ADDR_ADEN_HI = 8'h3E;

    // field positions
    localparam int DRIFT_BIT = 1;
    localparam int ACFG_MANUAL_BIT = 0;
    localparam int ACFG_384_BIT = 5;
    localparam int CRASH_LSB = 3;
    localparam int CRASH_W = 4;

    // reset values
    localparam logic [15:0] REG16_RESET = 16'h0000;
    localparam logic [31:0] REG32_RESET = 32'h0000_0000;

    // audio constant decode
    localparam logic [2:0] RATE_SEL_SPECIAL = 3'h4;
    localparam logic [11:0] N_DEFAULT = 12'hC00;
    localparam logic [11:0] N_SPECIAL_LOW = 12'h400;
    localparam logic [11:0] N_SPECIAL_384 = 12'h600;

    // timing: reference is declared lost after this long without an h pulse
    localparam int CLK_MHZ = 50;
    localparam int REF_LOSS_US = 100;
    localparam int REF_LOSS_CYC = REF_LOSS_US * CLK_MHZ;
    localparam int DRIFT_LINES = 1024;

    typedef enum logic [1:0] {
        ST_FREE = 2'b00,
        ST_CRASH = 2'b01,
        ST_DRIFT = 2'b10,
        ST_LOCKED = 2'b11
    } mgl_lock_e;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [15:0] wdata;
    } mgl_host_req_s;

    typedef struct packed {
        logic [31:0] num;
        logic [31:0] den;
    } mgl_ratio_s;

    typedef struct packed {
        mgl_lock_e st;
        logic [15:0] lock_ctl;
        logic [15:0] line_den;
        logic [15:0] frame_den;
        logic [15:0] frame_init;
        logic [15:0] crash_ctl;
        logic [15:0] acfg;
        logic [31:0] vnum;
        logic [31:0] vden;
        logic [31:0] anum;
        logic [31:0] aden;
        logic [15:0] rdata;
        logic rvalid;
        logic [15:0] lock_cnt;
        logic [15:0] line_cnt;
        logic [15:0] frame_cnt;
        logic [15:0] loss_cnt;
        logic ref_lost;
        logic reacq;
        logic line_armed;
        logic frame_armed;
        logic line_rst;
        logic frame_rst;
        logic [11:0] audio_n;
    } mgl_state_s;

    // n as a function of rate select and the 384fs enable
    function automatic logic [11:0] audio_n_of(input logic [2:0] sel, input logic en384);
        if (sel != RATE_SEL_SPECIAL) begin
            return N_DEFAULT;
        end else if (en384) begin
            return N_SPECIAL_384;
        end
        return N_SPECIAL_LOW;
    endfunction

endpackage

// [src/mgl_pin_sync.sv]
/*
 two-stage synchroniser with rising-edge pulse for the reference and strap pins.
 assumes pins are asynchronous to sys_clk; pulses last one cycle.
*/
`timescale 1ns/1ps
module mgl_pin_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
        logic [W-1:0] qd;
    } mgl_sync_s;

    mgl_sync_s r;
    mgl_sync_s next_r;

    // meta feeds only q; edges come from q and qd
    always_comb begin
        next_r = r;
        next_r.meta = pin;
        next_r.q = r.meta;
        next_r.qd = r.q;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.q;
    assign rise = r.q & ~r.qd;
endmodule // mgl_pin_sync

// [src/mgl_genlock_setup.sv]
/*
 manual genlock ratio setup: host registers for video and audio divide ratios,
 line/frame counter reset arming, crash or drift lock sequencing, reference loss.
 assumes a same-clock host word port and asynchronous href/vref/genlock pins.
*/
`timescale 1ns/1ps
module mgl_genlock_setup
    import mgl_pkg::*;
#(
    parameter int REF_LOSS_CYCLES = REF_LOSS_CYC,
    parameter int DRIFT_LOCK_LINES = DRIFT_LINES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire mgl_pkg::mgl_host_req_s host_req,
    output logic [15:0] host_rdata,
    output logic host_rvalid,
    input wire logic href_pin,
    input wire logic vref_pin,
    input wire logic genlock_req_n_pin,
    input wire logic [2:0] audio_rate_select,
    output logic lock_lost,
    output logic ref_lost,
    output logic crash_locking,
    output logic drift_locking,
    output logic line_counter_reset,
    output logic frame_counter_reset,
    output mgl_pkg::mgl_ratio_s video_ratio,
    output mgl_pkg::mgl_ratio_s audio_ratio,
    output logic audio_manual,
    output logic [11:0] audio_n
);
    import mgl_pkg::*;

    logic [5:0] pin_level;
    logic [5:0] pin_rise;
    logic href_rise;
    logic vref_rise;
    logic genlock_req_n;
    logic [2:0] rate_sel;
    logic [15:0] crash_limit;
    logic attempt;
    mgl_state_s r;
    mgl_state_s next_r;

    // all pins are async, so all go through the synchroniser
    mgl_pin_sync #(.W(6)) mgl_pin_sync_inst (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin({audio_rate_select, genlock_req_n_pin, vref_pin, href_pin}),
        .level(pin_level),
        .rise(pin_rise)
    );

    assign href_rise = pin_rise[0];
    assign vref_rise = pin_rise[1];
    assign genlock_req_n = pin_level[2];
    assign rate_sel = pin_level[5:3];
    assign crash_limit = {12'h000, r.crash_ctl[CRASH_LSB +: CRASH_W]};
    assign attempt = !r.ref_lost && !genlock_req_n;

    // read mux; unmapped addresses read zero
    function automatic logic [15:0] rd_mux(input mgl_state_s s, input logic [7:0] a);
        if (a == ADDR_LOCK_CTL) begin
            return s.lock_ctl;
        end else if (a == ADDR_LINE_DEN) begin
            return s.line_den;
        end else if (a == ADDR_FRAME_DEN) begin
            return s.frame_den;
        end else if (a == ADDR_FRAME_INIT) begin
            return s.frame_init;
        end else if (a == ADDR_CRASH_CTL) begin
            return s.crash_ctl;
        end else if (a == ADDR_VNUM_LO) begin
            return s.vnum[15:0];
        end else if (a == ADDR_VNUM_HI) begin
            return s.vnum[31:16];
        end else if (a == ADDR_VDEN_LO) begin
            return s.vden[15:0];
        end else if (a == ADDR_VDEN_HI) begin
            return s.vden[31:16];
        end else if (a == ADDR_ACFG) begin
            return s.acfg;
        end else if (a == ADDR_ANUM_LO) begin
            return s.anum[15:0];
        end else if (a == ADDR_ANUM_HI) begin
            return s.anum[31:16];
        end else if (a == ADDR_ADEN_LO) begin
            return s.aden[15:0];
        end else if (a == ADDR_ADEN_HI) begin
            return s.aden[31:16];
        end
        return 16'h0000;
    endfunction

    always_comb begin
        next_r = r;
        next_r.line_rst = 1'b0;
        next_r.frame_rst = 1'b0;
        next_r.rvalid = host_req.re;
        if (host_req.re) begin
            next_r.rdata = rd_mux(r, host_req.addr);
        end
        // host writes; lower address is the low half of a pair
        if (host_req.we) begin
            if (host_req.addr == ADDR_LOCK_CTL) begin
                next_r.lock_ctl = host_req.wdata;
            end else if (host_req.addr == ADDR_LINE_DEN) begin
                next_r.line_den = host_req.wdata;
                next_r.line_armed = 1'b1;
                next_r.line_cnt = 16'h0000;
            end else if (host_req.addr == ADDR_FRAME_DEN) begin
                next_r.frame_den = host_req.wdata;
            end else if (host_req.addr == ADDR_FRAME_INIT) begin
                next_r.frame_init = host_req.wdata;
                next_r.frame_armed = 1'b1;
                next_r.frame_cnt = 16'h0000;
            end else if (host_req.addr == ADDR_CRASH_CTL) begin
                next_r.crash_ctl = host_req.wdata;
            end else if (host_req.addr == ADDR_VNUM_LO) begin
                next_r.vnum[15:0] = host_req.wdata;
            end else if (host_req.addr == ADDR_VNUM_HI) begin
                next_r.vnum[31:16] = host_req.wdata;
            end else if (host_req.addr == ADDR_VDEN_LO) begin
                next_r.vden[15:0] = host_req.wdata;
            end else if (host_req.addr == ADDR_VDEN_HI) begin
                next_r.vden[31:16] = host_req.wdata;
            end else if (host_req.addr == ADDR_ACFG) begin
                next_r.acfg = host_req.wdata;
            end else if (host_req.addr == ADDR_ANUM_LO) begin
                next_r.anum[15:0] = host_req.wdata;
            end else if (host_req.addr == ADDR_ANUM_HI) begin
                next_r.anum[31:16] = host_req.wdata;
            end else if (host_req.addr == ADDR_ADEN_LO) begin
                next_r.aden[15:0] = host_req.wdata;
            end else if (host_req.addr == ADDR_ADEN_HI) begin
                next_r.aden[31:16] = host_req.wdata;
            end
        end
        // n tracks the pins and the 384fs bit continuously
        next_r.audio_n = audio_n_of(rate_sel, r.acfg[ACFG_384_BIT]);
        // reference loss watchdog on the h pulse
        if (href_rise) begin
            next_r.loss_cnt = 16'h0000;
            next_r.ref_lost = 1'b0;
        end else if (r.loss_cnt >= 16'(REF_LOSS_CYCLES - 1)) begin
            next_r.ref_lost = 1'b1;
        end else begin
            next_r.loss_cnt = r.loss_cnt + 16'h0001;
        end
        // lock sequencing
        case (r.st)
            ST_FREE: begin
                if (attempt) begin
                    next_r.lock_cnt = 16'h0000;
                    if (r.lock_ctl[DRIFT_BIT] || r.reacq) begin
                        next_r.st = ST_DRIFT;
                    end else begin
                        next_r.st = ST_CRASH;
                    end
                end
            end
            ST_CRASH, ST_DRIFT: begin
                if (!attempt) begin
                    next_r.st = ST_FREE;
                    next_r.reacq = r.ref_lost && !genlock_req_n;
                end else if (href_rise) begin
                    if (r.st == ST_CRASH && r.lock_cnt >= crash_limit) begin
                        next_r.st = ST_LOCKED;
                    end else if (r.st == ST_DRIFT &&
                                 r.lock_cnt >= 16'(DRIFT_LOCK_LINES)) begin
                        next_r.st = ST_LOCKED;
                    end else begin
                        next_r.lock_cnt = r.lock_cnt + 16'h0001;
                    end
                end
            end
            ST_LOCKED: begin
                next_r.reacq = 1'b0;
                if (!attempt) begin
                    next_r.st = ST_FREE;
                    next_r.reacq = r.ref_lost && !genlock_req_n;
                end
            end
            default: begin
                next_r.st = ST_FREE;
            end
        endcase
        // line and frame reset counters run independently, so both may fire
        if (r.st != ST_FREE && href_rise && r.line_armed && r.line_den != 16'h0000) begin
            if (r.line_cnt + 16'h0001 >= r.line_den) begin
                next_r.line_cnt = 16'h0000;
                next_r.line_rst = 1'b1;
            end else begin
                next_r.line_cnt = r.line_cnt + 16'h0001;
            end
        end
        if (r.st != ST_FREE && vref_rise && r.frame_armed && r.frame_den != 16'h0000) begin
            if (r.frame_cnt + 16'h0001 >= r.frame_den) begin
                next_r.frame_cnt = 16'h0000;
                next_r.frame_rst = 1'b1;
            end else begin
                next_r.frame_cnt = r.frame_cnt + 16'h0001;
            end
        end
    end

    // reference starts lost so no lock is tried before the first h pulse
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.st <= ST_FREE;
            r.lock_ctl <= REG16_RESET;
            r.crash_ctl <= REG16_RESET;
            r.acfg <= REG16_RESET;
            r.vnum <= REG32_RESET;
            r.vden <= REG32_RESET;
            r.ref_lost <= 1'b1;
            r.audio_n <= N_DEFAULT;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from state flops
    assign host_rdata = r.rdata;
    assign host_rvalid = r.rvalid;
    assign lock_lost = (r.st != ST_LOCKED);
    assign ref_lost = r.ref_lost;
    assign crash_locking = (r.st == ST_CRASH);
    assign drift_locking = (r.st == ST_DRIFT);
    assign line_counter_reset = r.line_rst;
    assign frame_counter_reset = r.frame_rst;
    assign video_ratio = '{num: r.vnum, den: r.vden};
    assign audio_ratio = '{num: r.anum, den: r.aden};
    assign audio_manual = r.acfg[ACFG_MANUAL_BIT];
    assign audio_n = r.audio_n;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_attempt_gate;
        (r.st != ST_FREE && $past(r.st) == ST_FREE) |-> $past(attempt);
    endproperty
    a_attempt_gate: assert property (p_attempt_gate)
        else $error("lock started without reference or request");

    property p_drift_select;
        ($past(r.st) == ST_FREE && r.st == ST_DRIFT) |->
            $past(r.lock_ctl[DRIFT_BIT] || r.reacq);
    endproperty
    a_drift_select: assert property (p_drift_select)
        else $error("drift lock without drift bit or reacquire");

    property p_crash_default;
        ($past(r.st) == ST_FREE && r.st == ST_CRASH) |->
            $past(!r.lock_ctl[DRIFT_BIT] && !r.reacq);
    endproperty
    a_crash_default: assert property (p_crash_default)
        else $error("crash lock chosen while drift required");

    property p_reacq_drift;
        (r.st == ST_FREE && r.reacq && attempt) |=> (r.st == ST_DRIFT);
    endproperty
    a_reacq_drift: assert property (p_reacq_drift)
        else $error("reapplied reference did not drift lock");

    property p_lock_lost_fall;
        $fell(lock_lost) |-> ($past(r.st) inside {ST_CRASH, ST_DRIFT}) && $past(href_rise);
    endproperty
    a_lock_lost_fall: assert property (p_lock_lost_fall)
        else $error("lock lost fell outside a locking interval");

    property p_crash_time;
        ($past(r.st) == ST_CRASH && r.st == ST_LOCKED) |-> $past(r.lock_cnt >= crash_limit);
    endproperty
    a_crash_time: assert property (p_crash_time)
        else $error("crash lock ended before crash time");

    property p_audio_n;
        ##1 (r.audio_n == audio_n_of($past(rate_sel), $past(r.acfg[ACFG_384_BIT])));
    endproperty
    a_audio_n: assert property (p_audio_n)
        else $error("audio constant n wrong");

    property p_en384_reset;
        $past(sys_rst) |-> !r.acfg[ACFG_384_BIT];
    endproperty
    a_en384_reset: assert property (p_en384_reset)
        else $error("384fs enable not zero after reset");

    property p_pair_low;
        (host_req.we && host_req.addr == ADDR_VDEN_LO) |=>
            (r.vden[15:0] == $past(host_req.wdata)) && $stable(r.vden[31:16]);
    endproperty
    a_pair_low: assert property (p_pair_low)
        else $error("low address did not load low half");

    property p_frame_armed;
        frame_counter_reset |-> r.frame_armed && $past(vref_rise);
    endproperty
    a_frame_armed: assert property (p_frame_armed)
        else $error("frame reset without frame divider init");

    property p_line_armed;
        line_counter_reset |-> r.line_armed && $past(href_rise);
    endproperty
    a_line_armed: assert property (p_line_armed)
        else $error("line reset without line register");

    c_crash_lock: cover property ($past(r.st) == ST_CRASH && r.st == ST_LOCKED);
    c_drift_lock: cover property ($past(r.st) == ST_DRIFT && r.st == ST_LOCKED);
    c_two_resets: cover property (line_counter_reset ##[1:200] frame_counter_reset);
    c_ref_loss: cover property ($rose(ref_lost) ##[1:50] r.reacq);
endmodule // mgl_genlock_setup

// [dv/mgl_ref_source.sv]
/*
 behavioural reference source: href pulse every H_PERIOD clocks and a vref pulse
 on the first line of every V_LINES lines, both silent (low) while run is low.
 assumes it shares the bench clock; the block treats both pins as asynchronous.
*/
`timescale 1ns/1ps
module mgl_ref_source #(
    parameter int H_PERIOD = 12,
    parameter int V_LINES = 5
) (
    input wire logic clk,
    input wire logic run,
    output logic href,
    output logic vref
);
    int h_cnt = 0;
    int v_cnt = 0;

    // pulses are two clocks wide so the two-flop sync cannot miss them
    always @(negedge clk) begin
        if (!run) begin
            h_cnt <= 0;
            v_cnt <= 0;
            href <= 1'b0;
            vref <= 1'b0;
        end else begin
            h_cnt <= (h_cnt == H_PERIOD - 1) ? 0 : h_cnt + 1;
            if (h_cnt == H_PERIOD - 1) begin
                v_cnt <= (v_cnt == V_LINES - 1) ? 0 : v_cnt + 1;
            end
            href <= (h_cnt < 2);
            vref <= (h_cnt < 2) && (v_cnt == 0);
        end
    end
endmodule // mgl_ref_source

// [dv/test_mgl_genlock_setup.sv]
/*
 self-checking bench for the genlock ratio setup block: host map, ratio pairing,
 audio constant decode, crash/drift locking and the line/frame counter resets.
 assumes the block's word port timing and shortened loss and drift counts.
*/
`timescale 1ns/1ps
module test_mgl_genlock_setup;
    import mgl_pkg::*;
    localparam int HP = 12;
    localparam int VL = 5;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    mgl_host_req_s host_req = '0;
    logic ref_run = 1'b0;
    logic genlock_req_n_pin = 1'b1;
    logic [2:0] audio_rate_select = 3'h0;
    logic href_pin;
    logic vref_pin;
    logic [15:0] host_rdata;
    logic host_rvalid;
    logic lock_lost;
    logic ref_lost;
    logic crash_locking;
    logic drift_locking;
    logic line_counter_reset;
    logic frame_counter_reset;
    logic audio_manual;
    logic [11:0] audio_n;
    mgl_ratio_s video_ratio;
    mgl_ratio_s audio_ratio;
    int errors = 0;
    int n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    mgl_ref_source #(.H_PERIOD(HP), .V_LINES(VL)) mgl_ref_source_inst (
        .clk(sys_clk), .run(ref_run), .href(href_pin), .vref(vref_pin));

    mgl_genlock_setup #(.REF_LOSS_CYCLES(20), .DRIFT_LOCK_LINES(4)) mgl_genlock_setup_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .href_pin(href_pin),
        .vref_pin(vref_pin), .genlock_req_n_pin(genlock_req_n_pin),
        .audio_rate_select(audio_rate_select), .lock_lost(lock_lost),
        .ref_lost(ref_lost), .crash_locking(crash_locking),
        .drift_locking(drift_locking), .line_counter_reset(line_counter_reset),
        .frame_counter_reset(frame_counter_reset), .video_ratio(video_ratio),
        .audio_ratio(audio_ratio), .audio_manual(audio_manual), .audio_n(audio_n));

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // one-cycle write strobe, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        host_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        host_req <= '0;
    endtask

    // answer is registered on the taking edge and checked half a cycle later
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(negedge sys_clk);
        host_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge sys_clk);
        host_req <= '0;
        check(host_rvalid === 1'b1 && host_rdata === exp, "read data");
    endtask

    // bounded wait for lock, noting which locking style was shown meanwhile
    task automatic wait_lock(output logic cs, output logic ds);
        cs = 1'b0;
        ds = 1'b0;
        for (int i = 0; i < 200 && lock_lost !== 1'b0; i++) begin
            @(negedge sys_clk);
            cs = cs | (crash_locking === 1'b1);
            ds = ds | (drift_locking === 1'b1);
        end
        check(lock_lost === 1'b0, "no lock");
    endtask

    task automatic wait_pulse(input logic frame);
        int i;
        i = 0;
        do begin
            @(negedge sys_clk);
            i++;
        end while (i < 400 && (frame ? frame_counter_reset : line_counter_reset) !== 1'b1);
        check(i < 400, "no counter reset pulse");
    endtask

    task automatic t_reset();
        logic [7:0] map[14] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h24, 8'h28, 8'h29,
                                8'h2A, 8'h2B, 8'h31, 8'h3B, 8'h3C, 8'h3D, 8'h3E};
        check(lock_lost === 1'b1 && ref_lost === 1'b1, "lock flags after reset");
        check(audio_n === 12'hC00, "n after reset");
        foreach (map[i]) rd_chk(map[i], 16'h0000);
    endtask

    task automatic t_regs();
        wr(8'h28, 16'h126F);
        wr(8'h29, 16'h00A5);
        wr(8'h2A, 16'h0001);
        wr(8'h2B, 16'h5A00);
        wr(8'h31, 16'h0001);
        wr(8'h3B, 16'h0700);
        wr(8'h3C, 16'h0001);
        wr(8'h3D, 16'h0465);
        wr(8'h3E, 16'h0002);
        check(video_ratio === {32'h00A5_126F, 32'h5A00_0001}, "video ratio");
        check(audio_ratio === {32'h0001_0700, 32'h0002_0465}, "audio ratio");
        check(audio_manual === 1'b1, "audio manual flag");
        rd_chk(8'h2B, 16'h5A00);
        wr(8'h20, 16'hFFFF);
        rd_chk(8'h20, 16'h0000);
    endtask

    // every rate select code with the 384fs bit clear and set
    task automatic t_audio_n();
        logic [11:0] exp;
        for (int r = 0; r < 8; r++) begin
            for (int b = 0; b < 2; b++) begin
                wr(8'h31, b ? 16'h0020 : 16'h0000);
                audio_rate_select <= 3'(r);
                repeat (6) @(negedge sys_clk);
                exp = (r != 4) ? 12'hC00 : (b ? 12'h600 : 12'h400);
                check(audio_n === exp, "audio n decode");
            end
        end
    endtask

    task automatic t_crash();
        logic cs;
        logic ds;
        wr(8'h24, 16'h0010);
        ref_run <= 1'b1;
        repeat (40) @(negedge sys_clk);
        check(ref_lost === 1'b0 && lock_lost === 1'b1, "no lock without request");
        check(crash_locking === 1'b0 && drift_locking === 1'b0, "idle while unrequested");
        genlock_req_n_pin <= 1'b0;
        wait_lock(cs, ds);
        check(cs === 1'b1 && ds === 1'b0, "default crash lock");
    endtask

    task automatic t_reacq();
        logic cs;
        logic ds;
        ref_run <= 1'b0;
        repeat (40) @(negedge sys_clk);
        check(ref_lost === 1'b1 && lock_lost === 1'b1, "reference loss");
        ref_run <= 1'b1;
        wait_lock(cs, ds);
        check(ds === 1'b1 && cs === 1'b0, "drift lock on reacquire");
    endtask

    task automatic t_drift();
        logic cs;
        logic ds;
        genlock_req_n_pin <= 1'b1;
        repeat (10) @(negedge sys_clk);
        check(lock_lost === 1'b1, "lock dropped with request");
        wr(8'h16, 16'h0002);
        genlock_req_n_pin <= 1'b0;
        wait_lock(cs, ds);
        check(ds === 1'b1 && cs === 1'b0, "drift lock by control bit");
    endtask

    // all three written: both counter resets run, each at its own spacing
    task automatic t_resets();
        time t0;
        wr(8'h17, 16'h0003);
        wr(8'h18, 16'h0002);
        wr(8'h19, 16'h0001);
        wait_pulse(1'b0);
        t0 = $time;
        wait_pulse(1'b0);
        check(($time - t0) == 3 * HP * 20, "line reset spacing");
        wait_pulse(1'b1);
        t0 = $time;
        wait_pulse(1'b1);
        check(($time - t0) == 2 * VL * HP * 20, "frame reset spacing");
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // runtime is several hundred cycles; this bound only catches a hang
    initial begin
        #(20 * 20000);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_regs();
        t_audio_n();
        t_crash();
        t_reacq();
        t_drift();
        t_resets();
        close_out();
    end
endmodule // test_mgl_genlock_setup
